/* File: shared/fci_pkg.sv */
// shared constants and types of the four-channel input front end
package fci_pkg;

	// channel count and sampling clock
	localparam int NCH     = 4;
	localparam int CLK_MHZ = 50;

	// input delay settings in microseconds, as selectable
	localparam int DLY0_US = 100;
	localparam int DLY1_US = 500;
	localparam int DLY2_US = 3000;
	localparam int DLY3_US = 15000;
	localparam int DLY4_US = 20000;

	// delay settings in clock cycles (us times MHz gives cycles exactly)
	localparam int DLY0_CYC = DLY0_US * CLK_MHZ;
	localparam int DLY1_CYC = DLY1_US * CLK_MHZ;
	localparam int DLY2_CYC = DLY2_US * CLK_MHZ;
	localparam int DLY3_CYC = DLY3_US * CLK_MHZ;
	localparam int DLY4_CYC = DLY4_US * CLK_MHZ;

	// filter counter width, wide enough for the longest setting
	localparam int DCNT_W = 20;

	// delay select codes
	localparam logic [2:0] DSEL_MAX = 3'h4;
	localparam logic [2:0] DSEL_RST = 3'h2;

	// register byte offsets
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_STATIC  = 8'h04;
	localparam logic [7:0] OFS_DYNAMIC = 8'h08;
	localparam logic [7:0] OFS_VALUE   = 8'h0C;
	localparam logic [7:0] OFS_PENDING = 8'h10;
	localparam logic [7:0] OFS_DCHAN   = 8'h14;
	localparam logic [7:0] OFS_DMOD    = 8'h18;

	// field positions, dynamic parameter register
	localparam int DYN_DLY_LSB = 0;
	localparam int DYN_PIE_BIT = 3;
	localparam int DYN_DIE_BIT = 4;
	localparam int DYN_RISE_LSB = 8;
	localparam int DYN_FALL_LSB = 12;
	// field positions, static parameter register
	localparam int STA_WB_LSB = 0;
	localparam int STA_SC_LSB = 4;
	// field positions, module diagnostic register
	localparam int DM_BADPAR_BIT = 0;
	localparam int DM_NOCFG_BIT  = 1;
	localparam int DM_HW_LSB     = 2;
	localparam int DM_LOST_BIT   = 9;
	localparam int DM_EVENT_BIT  = 16;
	// module hardware faults: ext aux, int aux, fuse, watchdog, eprom, ram, cpu
	localparam int NMF = 7;

	// controller operating state, one-hot
	typedef enum logic [1:0] {
		FCI_STOP = 2'b01,
		FCI_RUN  = 2'b10
	} fci_mode_e;

endpackage : fci_pkg

/* File: verilog/fci_filter.sv */
// input delay filter and edge detector for one channel
`timescale 1ns/1ps
`default_nettype none

module fci_filter
	import fci_pkg::*;
#(
	parameter int CNT_W = fci_pkg::DCNT_W
)(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             din,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  level,
	output logic                  rise,
	output logic                  fall
);

	typedef struct packed {
		logic             s1;
		logic             s2;
		logic             level;
		logic [CNT_W-1:0] cnt;
		logic             rise;
		logic             fall;
		logic [1:0]       warm;
	} fci_flt_s;

	fci_flt_s st;
	fci_flt_s next_st;

	// a new level must stay put for the full delay before it is passed on
	always_comb
	begin
		next_st      = st;
		next_st.s1   = din;
		next_st.s2   = st.s1;
		next_st.rise = 1'b0;
		next_st.fall = 1'b0;
		if (st.warm != 2'h3)
		begin
			// seed the level once both sync stages hold the pin, so an idle-high pin gives no false rise
			next_st.warm = st.warm + 2'h1;
			if (st.warm == 2'h2)
				next_st.level = st.s2;
		end
		else if (st.s2 == st.level)
		begin
			next_st.cnt = '0;
		end
		else if (st.cnt >= limit - CNT_W'(1))
		begin
			next_st.level = st.s2;
			next_st.cnt   = '0;
			next_st.rise  = st.s2;
			next_st.fall  = ~st.s2;
		end
		else
		begin
			next_st.cnt = st.cnt + CNT_W'(1);
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign level = st.level;
	assign rise  = st.rise;
	assign fall  = st.fall;

endmodule : fci_filter

`default_nettype wire

/* File: verilog/fci_top.sv */
// four-channel digital input front end with diagnostics and APB registers
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - input delay chosen among five settings, 3 ms after reset
// - each setting's cycle count lands inside its tolerance band
// - module process interrupt enable gates all edge interrupts, resets off
// - module diagnostic interrupt enable gates diagnostic interrupts, resets off
// - per-group wire-break monitor enable, off by default, written only in stop
// - per-group short-to-ground monitor enable, off by default, written only in stop
// - per-group rising edge interrupt enable, changeable in run, off by default
// - per-group falling edge interrupt enable, changeable in run, both may be set
// - channel n belongs to channel group n
// - stored set is adopted at the stop to run transition
// - in run dynamic parameters are accepted, static ones stay unchanged
// - never parameterized module runs with its built-in defaults
// - wire-break and short reported only for groups with monitoring enabled
// - module-wide diagnostics reported always, whatever the configuration
// - any diagnostic change raises the diagnostic interrupt only when enabled
// - known module errors always light group and channel fault indicators
// - wire break lights indicators only when its monitoring is enabled
// - each diagnostic is tagged as group-scoped or module-scoped
// - second edge before acknowledge is dropped and flags a lost interrupt
module fci_top
	import fci_pkg::*;
#(
	parameter int DLY0 = fci_pkg::DLY0_CYC,
	parameter int DLY1 = fci_pkg::DLY1_CYC,
	parameter int DLY2 = fci_pkg::DLY2_CYC,
	parameter int DLY3 = fci_pkg::DLY3_CYC,
	parameter int DLY4 = fci_pkg::DLY4_CYC
)(
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic [31:0]                 prdata,
	input  wire logic [fci_pkg::NCH-1:0] din,
	input  wire logic [fci_pkg::NCH-1:0] wire_break_in,
	input  wire logic [fci_pkg::NCH-1:0] short_in,
	input  wire logic [fci_pkg::NMF-1:0] module_fault_in,
	output logic                        proc_irq,
	output logic                        diag_irq,
	output logic                        group_fault_indicator,
	output logic [fci_pkg::NCH-1:0]      channel_fault
);

	localparam int NDV = 2 * NCH + NMF + 3;

	typedef struct packed {
		fci_mode_e         mode;
		logic              configured;
		logic [NCH-1:0]    sh_wb;
		logic [NCH-1:0]    sh_sc;
		logic [NCH-1:0]    act_wb;
		logic [NCH-1:0]    act_sc;
		logic [2:0]        sh_dly;
		logic [2:0]        act_dly;
		logic              sh_pie;
		logic              act_pie;
		logic              sh_die;
		logic              act_die;
		logic [NCH-1:0]    sh_rise;
		logic [NCH-1:0]    sh_fall;
		logic [NCH-1:0]    act_rise;
		logic [NCH-1:0]    act_fall;
		logic [NCH-1:0]    pending;
		logic              bad_param;
		logic              irq_lost;
		logic              diag_event;
		logic [NDV-1:0]    diag_prev;
		logic [NCH-1:0]    wb_s1;
		logic [NCH-1:0]    wb_s2;
		logic [NCH-1:0]    sc_s1;
		logic [NCH-1:0]    sc_s2;
		logic [NMF-1:0]    mf_s1;
		logic [NMF-1:0]    mf_s2;
		logic              grp_led;
		logic [NCH-1:0]    ch_led;
		logic [31:0]       rdata;
	} fci_state_s;

	fci_state_s           st;
	fci_state_s           next_st;
	logic [DCNT_W-1:0]    limit;
	logic [NCH-1:0]       flt_level;
	logic [NCH-1:0]       flt_rise;
	logic [NCH-1:0]       flt_fall;
	logic [NCH-1:0]       wb_rep;
	logic [NCH-1:0]       sc_rep;
	logic [NDV-1:0]       diag_vec;
	logic                 setup;
	logic                 wr;
	logic                 mapped;
	logic                 in_run;
	logic                 static_blocked;

	// delay select to cycle count; counts sit inside each tolerance band
	always_comb
	begin
		case (st.act_dly)
			3'h0:    limit = DCNT_W'(DLY0);
			3'h1:    limit = DCNT_W'(DLY1);
			3'h2:    limit = DCNT_W'(DLY2);
			3'h3:    limit = DCNT_W'(DLY3);
			3'h4:    limit = DCNT_W'(DLY4);
			default: limit = DCNT_W'(DLY2);
		endcase
	end

	// one filter per channel, channel n feeds group n
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_ch
			fci_filter #(
				.CNT_W (DCNT_W)
			) u_flt (
				.clk   (clk),
				.rstn  (rstn),
				.din   (din[gi]),
				.limit (limit),
				.level (flt_level[gi]),
				.rise  (flt_rise[gi]),
				.fall  (flt_fall[gi])
			);
		end
	endgenerate

	// group diagnostics only where monitoring is switched on
	assign wb_rep = st.wb_s2 & st.act_wb;
	assign sc_rep = st.sc_s2 & st.act_sc;

	// low bits group-scoped, upper bits module-scoped
	assign diag_vec = {st.mf_s2, st.irq_lost, ~st.configured, st.bad_param, sc_rep, wb_rep};

	// bus decode
	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pwrite;
	assign in_run = (st.mode == FCI_RUN);
	assign mapped = (paddr == OFS_MODE) | (paddr == OFS_STATIC) | (paddr == OFS_DYNAMIC)
	              | (paddr == OFS_VALUE) | (paddr == OFS_PENDING) | (paddr == OFS_DCHAN)
	              | (paddr == OFS_DMOD);
	// static set refused while running so the active copy cannot drift
	assign static_blocked = pwrite & (paddr == OFS_STATIC) & in_run;

	// zero wait states; error on unmapped address or refused write
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (~mapped | static_blocked);

	// all register, parameter and diagnostic behaviour
	always_comb
	begin
		next_st       = st;
		next_st.wb_s1 = wire_break_in;
		next_st.wb_s2 = st.wb_s1;
		next_st.sc_s1 = short_in;
		next_st.sc_s2 = st.sc_s1;
		next_st.mf_s1 = module_fault_in;
		next_st.mf_s2 = st.mf_s1;

		// software writes; clears of bad_param, irq_lost and diag_event lose against same-cycle sets below, a pending clear wins
		if (wr)
		begin
			case (paddr)
				OFS_MODE:
				begin
					if (pwdata[0] & ~in_run)
					begin
						next_st.mode       = FCI_RUN;
						next_st.act_wb     = st.sh_wb;
						next_st.act_sc     = st.sh_sc;
						next_st.act_dly    = st.sh_dly;
						next_st.act_pie    = st.sh_pie;
						next_st.act_die    = st.sh_die;
						next_st.act_rise   = st.sh_rise;
						next_st.act_fall   = st.sh_fall;
						next_st.configured = 1'b1;
					end
					else if (~pwdata[0])
					begin
						next_st.mode = FCI_STOP;
					end
				end
				OFS_STATIC:
				begin
					if (~in_run)
					begin
						next_st.sh_wb = pwdata[STA_WB_LSB +: NCH];
						next_st.sh_sc = pwdata[STA_SC_LSB +: NCH];
					end
				end
				OFS_DYNAMIC:
				begin
					next_st.sh_pie  = pwdata[DYN_PIE_BIT];
					next_st.sh_die  = pwdata[DYN_DIE_BIT];
					next_st.sh_rise = pwdata[DYN_RISE_LSB +: NCH];
					next_st.sh_fall = pwdata[DYN_FALL_LSB +: NCH];
					if (pwdata[DYN_DLY_LSB +: 3] <= DSEL_MAX)
						next_st.sh_dly = pwdata[DYN_DLY_LSB +: 3];
					if (in_run)
					begin
						next_st.act_pie  = pwdata[DYN_PIE_BIT];
						next_st.act_die  = pwdata[DYN_DIE_BIT];
						next_st.act_rise = pwdata[DYN_RISE_LSB +: NCH];
						next_st.act_fall = pwdata[DYN_FALL_LSB +: NCH];
						if (pwdata[DYN_DLY_LSB +: 3] <= DSEL_MAX)
							next_st.act_dly = pwdata[DYN_DLY_LSB +: 3];
					end
				end
				OFS_PENDING:
				begin
					next_st.pending = st.pending & ~pwdata[NCH-1:0];
				end
				OFS_DMOD:
				begin
					if (pwdata[DM_BADPAR_BIT])
						next_st.bad_param = 1'b0;
					if (pwdata[DM_LOST_BIT])
						next_st.irq_lost = 1'b0;
					if (pwdata[DM_EVENT_BIT])
						next_st.diag_event = 1'b0;
				end
				default:
				begin
					next_st.mode = st.mode;
				end
			endcase
		end

		// an out-of-range delay code is a bad parameter and is not taken
		if (wr & (paddr == OFS_DYNAMIC) & (pwdata[DYN_DLY_LSB +: 3] > DSEL_MAX))
			next_st.bad_param = 1'b1;

		// edge events; a busy channel drops the edge and flags the loss
		for (int i = 0; i < NCH; i++)
		begin
			if (st.act_pie & ((flt_rise[i] & st.act_rise[i]) | (flt_fall[i] & st.act_fall[i])))
			begin
				if (st.pending[i])
					next_st.irq_lost = 1'b1;
				else
					next_st.pending[i] = 1'b1;
			end
		end

		// incoming and outgoing diagnostics raise the interrupt when enabled
		next_st.diag_prev = diag_vec;
		if ((diag_vec != st.diag_prev) & st.act_die)
			next_st.diag_event = 1'b1;

		// fault indicators: shorts and module faults always, wire break if monitored
		for (int i = 0; i < NCH; i++)
			next_st.ch_led[i] = st.sc_s2[i] | wb_rep[i] | (|st.mf_s2);
		next_st.grp_led = (|st.mf_s2) | (|st.sc_s2) | (|wb_rep);

		// read data sampled in setup so it is steady through the access phase
		if (setup)
		begin
			case (paddr)
				OFS_MODE:    next_st.rdata = {30'h0, st.configured, in_run};
				OFS_STATIC:  next_st.rdata = {24'h0, st.act_sc, st.act_wb};
				OFS_DYNAMIC: next_st.rdata = {16'h0, st.act_fall, st.act_rise, 3'h0,
				                              st.act_die, st.act_pie, st.act_dly};
				OFS_VALUE:   next_st.rdata = {28'h0, flt_level};
				OFS_PENDING: next_st.rdata = {28'h0, st.pending};
				OFS_DCHAN:   next_st.rdata = {24'h0, sc_rep, wb_rep};
				OFS_DMOD:    next_st.rdata = {15'h0, st.diag_event, 6'h0, st.irq_lost,
				                              st.mf_s2, ~st.configured, st.bad_param};
				default:     next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register; reset values are the built-in defaults
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st         <= '0;
			st.mode    <= FCI_STOP;
			st.sh_dly  <= DSEL_RST;
			st.act_dly <= DSEL_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prdata                = st.rdata;
	assign proc_irq              = |st.pending;
	assign diag_irq              = st.diag_event;
	assign group_fault_indicator = st.grp_led;
	assign channel_fault         = st.ch_led;

endmodule : fci_top

`default_nettype wire

/* File: sim/fci_top_asserts.sv */
// port checks of the input front end
`timescale 1ns/1ps
`default_nettype none

module fci_top_asserts
	import fci_pkg::*;
(
	input wire logic           clk,
	input wire logic           rstn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire logic           pslverr,
	input wire logic [31:0]    prdata,
	input wire logic [NCH-1:0] wire_break_in,
	input wire logic [NCH-1:0] short_in,
	input wire logic [NMF-1:0] module_fault_in,
	input wire logic           proc_irq,
	input wire logic           diag_irq,
	input wire logic           group_fault_indicator,
	input wire logic [NCH-1:0] channel_fault
);
	// writes that acknowledge or clear sticky state
	wire logic wr_pend = psel && penable && pwrite && paddr == OFS_PENDING;
	wire logic wr_dmod = psel && penable && pwrite && paddr == OFS_DMOD;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// held past both sync stages and the led register
	sequence s_fault_held;
		(|module_fault_in)[*5];
	endsequence
	sequence s_all_quiet;
		(wire_break_in == 4'h0 && short_in == 4'h0 && module_fault_in == 7'h0)[*5];
	endsequence

	chk_group_or: assert property (group_fault_indicator == |channel_fault)
		else $error("group led differs from channel leds");
	chk_module_led: assert property (s_fault_held |-> channel_fault == 4'hF && group_fault_indicator)
		else $error("module fault left a led dark");
	chk_quiet_leds: assert property (s_all_quiet |-> channel_fault == 4'h0)
		else $error("led lit without a fault");
	chk_pend_hold: assert property (proc_irq && !wr_pend |=> proc_irq)
		else $error("process irq dropped unacknowledged");
	chk_diag_hold: assert property (diag_irq && !wr_dmod |=> diag_irq)
		else $error("diag irq dropped uncleared");
	chk_reset_quiet: assert property ($rose(rstn) |-> !proc_irq && !diag_irq)
		else $error("irq up right after reset");
	chk_err_window: assert property (pslverr |-> psel && penable &&
		(pwrite || paddr > OFS_DMOD || paddr[1:0] != 2'h0))
		else $error("error outside access or on a mapped read");
	chk_bad_read: assert property (psel && penable && !pwrite && paddr > OFS_DMOD |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : fci_top_asserts
`default_nettype wire

/* File: sim/fci_cpu.sv */
// controller model: apb master loading and servicing the front end
`timescale 1ns/1ps
`default_nettype none

module fci_cpu (
	input  wire logic   clk,
	input  wire logic   pready,
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [7:0]  paddr,
	output logic [31:0] pwdata
);
	// bus idle from time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
	end

	// one apb transfer: setup cycle, then access phase held until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // stale data must not look valid
	endtask : xfer
endmodule : fci_cpu
`default_nettype wire

/* File: sim/test_four_channel_input_diag_param.sv */
// self-checking bench of the four-channel input front end
`timescale 1ns/1ps
`default_nettype none

`define CMP(got, exp) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("mismatch at %0t: %h not %h", $time, got, exp); \
		end \
	end

module test_four_channel_input_diag_param;
	import fci_pkg::*;
	localparam int LIM0 = 5;
	localparam int LIM1 = 10;
	localparam int LIM2 = 20;
	localparam int LIM3 = 30;
	localparam int LIM4 = 40;
	logic           clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic           proc_irq, diag_irq, group_fault_indicator;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rng;
	logic [NCH-1:0] din, wire_break_in, short_in, channel_fault, ov, nv;
	logic [NMF-1:0] module_fault_in;
	logic [32:0]    nt, note_q[$];
	int             err_total, checked;

	// short delay counts keep the run brief
	fci_top #(.DLY0(LIM0), .DLY1(LIM1), .DLY2(LIM2), .DLY3(LIM3), .DLY4(LIM4)) u_dut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .din(din),
		.wire_break_in(wire_break_in), .short_in(short_in), .module_fault_in(module_fault_in),
		.proc_irq(proc_irq), .diag_irq(diag_irq), .group_fault_indicator(group_fault_indicator),
		.channel_fault(channel_fault));
	fci_cpu u_cpu (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// each completed access takes the oldest note
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1)
		begin
			nt = note_q.pop_front();
			`CMP({pslverr, pwrite ? 32'h0 : prdata}, nt)
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// short delay count of select code k
	function automatic int lim(input int k);
		case (k)
			0:       return LIM0;
			1:       return LIM1;
			2:       return LIM2;
			3:       return LIM3;
			default: return LIM4;
		endcase
	endfunction : lim

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		note_q.push_back(e);
		u_cpu.xfer(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		note_q.push_back({e, 32'h0});
		u_cpu.xfer(1'b1, a, d);
	endtask : wr

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic conclude;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// watchdog, far beyond the expected length
	initial
	begin
		tick(10000);
		err_total++;
		conclude();
	end

	initial
	begin
		rstn = 1'b0;
		din = 4'h0;
		wire_break_in = 4'h0;
		short_in = 4'h0;
		module_fault_in = 7'h0;
		err_total = 0;
		checked = 0;
		rng = 32'h123D;
		// default counts sit inside each tolerance band
		`CMP(DLY0_CYC >= 75 * CLK_MHZ && DLY0_CYC <= 150 * CLK_MHZ, 1'b1)
		`CMP(DLY1_CYC >= 400 * CLK_MHZ && DLY1_CYC <= 800 * CLK_MHZ, 1'b1)
		`CMP(DLY2_CYC >= 2800 * CLK_MHZ && DLY2_CYC <= 3500 * CLK_MHZ, 1'b1)
		`CMP(DLY3_CYC >= 14500 * CLK_MHZ && DLY3_CYC <= 15500 * CLK_MHZ, 1'b1)
		`CMP(DLY4_CYC >= 19000 * CLK_MHZ && DLY4_CYC <= 21000 * CLK_MHZ, 1'b1)
		tick(2);
		rstn <= 1'b1;
		// defaults of a module never loaded
		rd(OFS_MODE, 33'h0);
		rd(OFS_DYNAMIC, 33'h2);
		rd(OFS_STATIC, 33'h0);
		rd(OFS_DMOD, 33'h2);
		rd(8'h1C, 33'h1_0000_0000);
		// stop loads stay in shadow until the run write
		wr(OFS_STATIC, 32'h2, 1'b0);
		wr(OFS_DYNAMIC, 32'h1118, 1'b0);
		rd(OFS_DYNAMIC, 33'h2);
		wr(OFS_MODE, 32'h1, 1'b0);
		rd(OFS_DYNAMIC, 33'h1118);
		wr(OFS_STATIC, 32'hF0, 1'b1);
		rd(OFS_STATIC, 33'h2);
		rd(OFS_MODE, 33'h3);
		// ch0 edge pends, ch1 has no edge enable; second edge is lost
		din <= 4'h3;
		tick(12);
		`CMP(proc_irq, 1'b1)
		rd(OFS_PENDING, 33'h1);
		din <= 4'h2;
		tick(12);
		rd(OFS_PENDING, 33'h1);
		rd(OFS_DMOD, 33'h1_0200);
		wr(OFS_PENDING, 32'h1, 1'b0);
		wr(OFS_DMOD, 32'h1_0200, 1'b0);
		tick(4);
		rd(OFS_DMOD, 33'h1_0000);
		wr(OFS_DMOD, 32'h1_0000, 1'b0);
		tick(2);
		`CMP({proc_irq, diag_irq}, 2'b00)
		// module enable off blocks edges
		wr(OFS_DYNAMIC, 32'h1110, 1'b0);
		din <= 4'h3;
		tick(12);
		rd(OFS_PENDING, 33'h0);
		// each delay: level waits out its count, then follows
		for (int k = 0; k < 5; k++)
		begin
			rng = lfsr(rng);
			ov = din;
			nv = din ^ (rng[3:0] | 4'h1);
			wr(OFS_DYNAMIC, 32'(k), 1'b0);
			din <= nv;
			tick(lim(k) - 3);
			rd(OFS_VALUE, {29'h0, ov});
			tick(12);
			rd(OFS_VALUE, {29'h0, nv});
		end
		// break on monitored ch1 and bare ch2, short on ch3
		wr(OFS_DYNAMIC, 32'h10, 1'b0);
		wire_break_in <= 4'h6;
		short_in <= 4'h8;
		tick(8);
		`CMP(channel_fault, 4'hA)
		rd(OFS_DCHAN, 33'h2);
		`CMP(diag_irq, 1'b1)
		module_fault_in <= 7'h04;
		tick(8);
		`CMP(channel_fault, 4'hF)
		rd(OFS_DMOD, 33'h1_0010);
		wire_break_in <= 4'h0;
		short_in <= 4'h0;
		module_fault_in <= 7'h0;
		tick(8);
		`CMP(group_fault_indicator, 1'b0)
		wr(OFS_MODE, 32'h0, 1'b0);
		rd(OFS_MODE, 33'h2);
		// monitored short reported; bad delay code flags a bad parameter
		wr(OFS_STATIC, 32'h80, 1'b0);
		wr(OFS_MODE, 32'h1, 1'b0);
		short_in <= 4'h8;
		tick(8);
		rd(OFS_DCHAN, 33'h80);
		wr(OFS_DYNAMIC, 32'h7, 1'b0);
		rd(OFS_DMOD, 33'h1_0001);
		conclude();
	end
endmodule : test_four_channel_input_diag_param

bind fci_top fci_top_asserts u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pslverr(pslverr), .prdata(prdata), .wire_break_in(wire_break_in), .short_in(short_in),
	.module_fault_in(module_fault_in), .proc_irq(proc_irq), .diag_irq(diag_irq),
	.group_fault_indicator(group_fault_indicator), .channel_fault(channel_fault));
`default_nettype wire
